// ==== inc/scs_pkg.sv ====
`default_nettype none
package scs_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_PIN_MODE = 4'h0; // clock_pin_mode_select
   localparam logic [3:0] ADDR_PCC = 4'h4;      // processor_clock_control
   localparam logic [3:0] ADDR_RCM = 4'h8;      // internal_osc_mode_reg
   localparam logic [3:0] ADDR_MCM = 4'hC;      // main_clock_mode_reg
   localparam int ADDR_W = 4;
   localparam int REG_W = 8;                   // Control registers, one byte

   // ------------------------------------------------------------
   // Reset values and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] PIN_MODE_RST = 8'h00;
   localparam logic [7:0] PCC_RST = 8'h00;
   localparam logic [7:0] PCC_WMASK = 8'h37;   // Bits 3, 6, 7 stay zero
   localparam int PCC_CSS_BIT = 4;             // 1: CPU on subsystem clock
   localparam int PIN_MAIN_BIT = 6;            // Main pins in clock mode
   localparam int PIN_SUB_BIT = 4;             // Sub pins in clock mode
   localparam int PIN_EXT_BIT = 7;             // Main pins take ext clock
   localparam int PIN_EXTS_BIT = 5;            // Sub pins take ext clock
   localparam int RCM_HALT_BIT = 0;
   localparam int MCM_PICK_BIT = 0;            // main_clock_pick_bit
   localparam int MCM_HIGHSPEED_SOURCE_PICK_BIT = 2;            // highspeed_source_pick
   localparam int MCM_MCS_BIT = 1;             // main_source_status (RO)
   localparam int MCM_CLS_BIT = 3;             // cpu_sub_status (RO)
   localparam int CLK_SWITCH_CYCLES = 1;       // CPU source change delay
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      SCS_SRC_INT = 2'b00,
      SCS_SRC_HS = 2'b01,
      SCS_SRC_SUB = 2'b10
   } scs_src_t;
endpackage : scs_pkg
`default_nettype wire

// ==== logic/scs_clock_ctrl.sv ====
// Overview of operation
// - After reset the pin mode register is zero and all four pins are ports.
// - The high-speed source pick bit accepts one change per reset.
// - Peripherals on the stopped peripheral clock do not run meanwhile.
// - The watchdog gets its own clock, free of the main clock selection.
// - The interval timer low-speed clock bypasses the main clock selection.
// - External peripheral clocks bypass selection, except capture timers.
// - A CPU clock source change takes effect one cycle after the write.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_ctrl (
   input wire logic clk_sys,            // System clock, 20 MHz
   input wire logic rst_n,              // Async reset, active low
   input wire logic wb_cyc_i,           // Wishbone cycle
   input wire logic wb_stb_i,           // Wishbone strobe
   input wire logic wb_we_i,            // Wishbone write enable
   input wire logic [3:0] wb_adr_i,     // Wishbone byte address
   input wire logic [3:0] wb_sel_i,     // Wishbone byte selects
   input wire logic [31:0] wb_dat_i,    // Wishbone write data
   output logic [31:0] wb_dat_o,        // Wishbone read data
   output logic wb_ack_o,               // Wishbone acknowledge
   input wire logic timer8_pick_lowspeed, // 8-bit timer picks low-speed clk
   input wire logic periph_pick_ext,    // Peripheral selects ext clock
   input wire logic capture_timer_ext,  // Capture timer edge-count source
   output logic main_pins_clock_mode,   // Main pins leave port use
   output logic sub_pins_clock_mode,    // Sub pins leave port use
   output logic main_pins_ext_input,    // Main pins take external clock
   output logic sub_pins_ext_input,     // Sub pins take external clock
   output logic internal_osc_run,       // Internal HS oscillator enable
   output logic [1:0] cpu_clock_src,    // Active CPU source
   output logic periph_clock_run,       // Prescaled peripheral clock on
   output logic periph_enable,          // Peripherals on prescaled clk
   output logic watchdog_own_clock,     // Watchdog on dedicated clock
   output logic timer8_bypass,          // Timer gets low-speed clock
   output logic periph_ext_bypass       // Peripheral uses ext clock direct
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] pin_mode, next_pin_mode;
   logic [7:0] processor_clock_control, next_pcc;
   logic halt, next_halt;
   logic pick, next_pick;
   logic highspeed_source_pick, next_highspeed_source_pick;
   logic highspeed_source_pick_used, next_highspeed_source_pick_used;
   logic [1:0] cpu_src, next_cpu_src;
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic bus_req;
   logic wr;
   logic rd;
   logic wr_pin;
   logic wr_pcc;
   logic wr_rcm;
   logic wr_mcm;
   logic [1:0] want_src;

   // Byte 0 carries every field, so lane 0 gates writes
   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      hit = (a == o);
   endfunction : hit

   // ------------------------------------------------------------
   // Requested CPU source from the control bits
   // ------------------------------------------------------------
   always_comb begin
      if (processor_clock_control[scs_pkg::PCC_CSS_BIT])
         want_src = scs_pkg::SCS_SRC_SUB;
      else if (pick)
         want_src = scs_pkg::SCS_SRC_HS;
      else
         want_src = scs_pkg::SCS_SRC_INT;
   end

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // A write lands on the edge where the master sees ack high, since
   // the master holds address and data unchanged until that edge
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign wr = bus_req && wb_we_i && ack && wb_sel_i[0];
   // Read data is taken in the request cycle so it stands with ack
   assign rd = bus_req && !wb_we_i && !ack;
   // One write strobe per register
   assign wr_pin = wr && hit(wb_adr_i, scs_pkg::ADDR_PIN_MODE);
   assign wr_pcc = wr && hit(wb_adr_i, scs_pkg::ADDR_PCC);
   assign wr_rcm = wr && hit(wb_adr_i, scs_pkg::ADDR_RCM);
   assign wr_mcm = wr && hit(wb_adr_i, scs_pkg::ADDR_MCM);

   // ------------------------------------------------------------
   // Bus handshake and read data
   // ------------------------------------------------------------
   // Ack one cycle after the request, dropped the next cycle
   always_comb begin
      next_ack = bus_req && !ack;
      next_rdata = scs_pkg::BUS_ZERO;
      // Unmapped addresses and write cycles read zero
      if (rd) begin
         if (hit(wb_adr_i, scs_pkg::ADDR_PIN_MODE))
            next_rdata[scs_pkg::REG_W-1:0] = pin_mode;
         else if (hit(wb_adr_i, scs_pkg::ADDR_PCC))
            next_rdata[scs_pkg::REG_W-1:0] = processor_clock_control;
         else if (hit(wb_adr_i, scs_pkg::ADDR_RCM))
            next_rdata[scs_pkg::RCM_HALT_BIT] = halt;
         else if (hit(wb_adr_i, scs_pkg::ADDR_MCM)) begin
            next_rdata[scs_pkg::MCM_PICK_BIT] = pick;
            next_rdata[scs_pkg::MCM_HIGHSPEED_SOURCE_PICK_BIT] = highspeed_source_pick;
            next_rdata[scs_pkg::MCM_MCS_BIT] =
               (cpu_src == scs_pkg::SCS_SRC_HS);
            next_rdata[scs_pkg::MCM_CLS_BIT] =
               (cpu_src == scs_pkg::SCS_SRC_SUB);
         end
      end
   end

   // Handshake registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         rdata <= scs_pkg::BUS_ZERO;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Pin mode register
   // ------------------------------------------------------------
   // Pins remain ports until software writes a clock mode
   always_comb begin
      next_pin_mode = pin_mode;
      if (wr_pin)
         next_pin_mode = wb_dat_i[scs_pkg::REG_W-1:0];
   end

   // Reset puts all four pins back to port use
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         pin_mode <= scs_pkg::PIN_MODE_RST;
      else
         pin_mode <= next_pin_mode;
   end

   // ------------------------------------------------------------
   // Processor clock register
   // ------------------------------------------------------------
   // Reserved bits forced to zero, so a careless write cannot set them
   always_comb begin
      next_pcc = processor_clock_control;
      if (wr_pcc)
         next_pcc = wb_dat_i[scs_pkg::REG_W-1:0]
            & scs_pkg::PCC_WMASK;
   end

   // Processor clock register storage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         processor_clock_control <= scs_pkg::PCC_RST;
      else
         processor_clock_control <= next_pcc;
   end

   // ------------------------------------------------------------
   // Internal oscillator halt
   // ------------------------------------------------------------
   // Software must move the CPU off this oscillator before halting it
   always_comb begin
      next_halt = halt;
      if (wr_rcm)
         next_halt = wb_dat_i[scs_pkg::RCM_HALT_BIT];
   end

   // Oscillator runs out of reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         halt <= 1'b0;
      else
         halt <= next_halt;
   end

   // ------------------------------------------------------------
   // Main clock mode register
   // ------------------------------------------------------------
   // The source pick bit locks after its first real change; writing
   // the value already held does not use up that one change
   always_comb begin
      next_pick = pick;
      next_highspeed_source_pick = highspeed_source_pick;
      next_highspeed_source_pick_used = highspeed_source_pick_used;
      if (wr_mcm) begin
         next_pick = wb_dat_i[scs_pkg::MCM_PICK_BIT];
         if (!highspeed_source_pick_used && wb_dat_i[scs_pkg::MCM_HIGHSPEED_SOURCE_PICK_BIT] != highspeed_source_pick) begin
            next_highspeed_source_pick = wb_dat_i[scs_pkg::MCM_HIGHSPEED_SOURCE_PICK_BIT];
            next_highspeed_source_pick_used = 1'b1;
         end
      end
   end

   // Lock clears only on reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pick <= 1'b0;
         highspeed_source_pick <= 1'b0;
         highspeed_source_pick_used <= 1'b0;
      end else begin
         pick <= next_pick;
         highspeed_source_pick <= next_highspeed_source_pick;
         highspeed_source_pick_used <= next_highspeed_source_pick_used;
      end
   end

   // ------------------------------------------------------------
   // CPU clock source
   // ------------------------------------------------------------
   // Switch lands one edge after the write lands, which gives the
   // one cycle of delay a source change needs
   always_comb begin
      next_cpu_src = want_src;
   end

   // CPU starts on the internal oscillator
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         cpu_src <= scs_pkg::SCS_SRC_INT;
      else
         cpu_src <= next_cpu_src;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Pins stay ports until software picks a clock mode
   assign main_pins_clock_mode = pin_mode[scs_pkg::PIN_MAIN_BIT];
   assign sub_pins_clock_mode = pin_mode[scs_pkg::PIN_SUB_BIT];
   assign main_pins_ext_input = pin_mode[scs_pkg::PIN_MAIN_BIT]
      & pin_mode[scs_pkg::PIN_EXT_BIT];
   assign sub_pins_ext_input = pin_mode[scs_pkg::PIN_SUB_BIT]
      & pin_mode[scs_pkg::PIN_EXTS_BIT];
   assign internal_osc_run = !halt;
   assign cpu_clock_src = cpu_src;
   // Prescaled clock follows highspeed_source_pick, not pick; halt stops it only while that bit is clear
   assign periph_clock_run = highspeed_source_pick ? 1'b1 : !halt;
   assign periph_enable = periph_clock_run;
   // Dedicated paths ignore pick and highspeed_source_pick entirely
   assign watchdog_own_clock = 1'b1;
   assign timer8_bypass = timer8_pick_lowspeed;
   assign periph_ext_bypass = periph_pick_ext && !capture_timer_ext;
   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;
endmodule : scs_clock_ctrl
`default_nettype wire

// ==== verif/scs_clock_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checks of the clock source control
// ------------------------------------------------------------
module scs_clock_ctrl_chk (
   input wire logic clk_sys, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic wb_we_i, // Bus direction
   input wire logic wb_ack_o, // Bus acknowledge
   input wire logic [3:0] wb_adr_i, // Bus address
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   input wire logic [31:0] wb_dat_o, // Read data
   input wire logic timer8_pick_lowspeed, // Timer low-speed select
   input wire logic periph_pick_ext, // Peripheral external select
   input wire logic capture_timer_ext, // Capture timer edge source
   input wire logic main_pins_clock_mode, // Main pins in clock mode
   input wire logic internal_osc_run, // Oscillator enable
   input wire logic periph_clock_run, // Prescaled clock on
   input wire logic periph_enable, // Peripherals on prescaled clock
   input wire logic watchdog_own_clock, // Watchdog clock path
   input wire logic timer8_bypass, // Timer low-speed path
   input wire logic periph_ext_bypass, // External clock path
   input wire logic [1:0] cpu_clock_src // Active CPU source
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Write seen in its ack cycle; lane 0 gates the store
   sequence s_wr_done(a);
      wb_ack_o && wb_we_i && wb_adr_i == a && wb_sel_i[0];
   endsequence
   // Main pin clock mode moves only on the edge after an acked write to pin mode
   property p_pin_cause;
      $changed(main_pins_clock_mode) |->
         $past(wb_ack_o) && $past(wb_we_i) && $past(wb_sel_i[0])
         && $past(wb_adr_i) == scs_pkg::ADDR_PIN_MODE;
   endproperty
   property p_pcc_zero;
      wb_ack_o && !wb_we_i && wb_adr_i == scs_pkg::ADDR_PCC |->
         wb_dat_o[7:6] == 2'b00 && !wb_dat_o[3];
   endproperty
   // Write lands on the ack edge; the enable follows right after it
   property p_halt;
      s_wr_done(scs_pkg::ADDR_RCM) |=>
         internal_osc_run == !$past(wb_dat_i[scs_pkg::RCM_HALT_BIT]);
   endproperty
   // Source moves one edge after the write lands on the ack edge
   property p_switch;
      $changed(cpu_clock_src) |-> $past(wb_ack_o, 2) && $past(wb_we_i, 2);
   endproperty
   property p_periph; !periph_clock_run |-> !periph_enable; endproperty
   property p_wdt; watchdog_own_clock; endproperty
   property p_t8; timer8_bypass == timer8_pick_lowspeed; endproperty
   property p_ext;
      periph_ext_bypass == (periph_pick_ext && !capture_timer_ext);
   endproperty
   a_pin_cause: assert property (p_pin_cause)
      else $error("pin mode moved without a write");
   a_pcc_zero: assert property (p_pcc_zero)
      else $error("reserved clock bits read back set");
   a_halt: assert property (p_halt)
      else $error("oscillator enable not following halt");
   a_switch: assert property (p_switch)
      else $error("cpu source moved at wrong time");
   a_periph: assert property (p_periph)
      else $error("peripherals enabled on stopped clock");
   a_wdt: assert property (p_wdt)
      else $error("watchdog lost own clock");
   a_t8: assert property (p_t8)
      else $error("timer low speed clock not passed");
   a_ext: assert property (p_ext)
      else $error("external clock bypass wrong");
endmodule : scs_clock_ctrl_chk
bind scs_clock_ctrl scs_clock_ctrl_chk u_chk (
   .clk_sys(clk_sys),
   .rst_n(rst_n),
   .wb_we_i(wb_we_i),
   .wb_ack_o(wb_ack_o),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .timer8_pick_lowspeed(timer8_pick_lowspeed),
   .periph_pick_ext(periph_pick_ext),
   .capture_timer_ext(capture_timer_ext),
   .main_pins_clock_mode(main_pins_clock_mode),
   .internal_osc_run(internal_osc_run),
   .periph_clock_run(periph_clock_run),
   .periph_enable(periph_enable),
   .watchdog_own_clock(watchdog_own_clock),
   .timer8_bypass(timer8_bypass),
   .periph_ext_bypass(periph_ext_bypass),
   .cpu_clock_src(cpu_clock_src)
);
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bench for the clock source control
// ------------------------------------------------------------
module tb;
   logic clk_sys = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'hF;
   logic [31:0] dat = 32'h0000_0000, dout, q;
   logic ack, t8 = 1'b0, pext = 1'b0, cext = 1'b0;
   logic m_clk, s_clk, m_ext, s_ext, osc, prun, pen, wdt, t8b, pxb;
   logic [1:0] src;
   int bad_count = 0, tests_run = 0;
   always #25 clk_sys = ~clk_sys;
   scs_clock_ctrl DUT (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
      .timer8_pick_lowspeed(t8), .periph_pick_ext(pext),
      .capture_timer_ext(cext), .main_pins_clock_mode(m_clk),
      .sub_pins_clock_mode(s_clk), .main_pins_ext_input(m_ext),
      .sub_pins_ext_input(s_ext), .internal_osc_run(osc),
      .cpu_clock_src(src), .periph_clock_run(prun), .periph_enable(pen),
      .watchdog_own_clock(wdt), .timer8_bypass(t8b),
      .periph_ext_bypass(pxb));
   task automatic test_done();
      $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   // One classic cycle; held until ack, bounded so a dead slave ends the run
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) chk(1'b0, "no ack");
      if (n >= 20) test_done();
      q = dout;
      {cyc, stb} <= 2'b00;
      #1;
   endtask : bus
   task automatic test_reset_pins();
      bus(1'b0, scs_pkg::ADDR_PIN_MODE, 32'h0000_0000);
      chk(q === 32'h0000_0000, "pin mode read");
      chk(m_clk === 1'b0 && s_clk === 1'b0, "pins");
      chk(osc === 1'b1 && src === 2'b00, "osc after reset");
      bus(1'b1, scs_pkg::ADDR_PIN_MODE, 32'h0000_00F0);
      chk({m_clk, s_clk, m_ext, s_ext} === 4'hF, "pin clock modes");
      $display("test_reset_pins done");
   endtask : test_reset_pins
   task automatic test_cpu_switch();
      bus(1'b1, scs_pkg::ADDR_PCC, 32'h0000_0037);
      chk(src === 2'b00, "sub switch one cycle late");
      @(posedge clk_sys);
      #1;
      chk(src === 2'b10, "cpu on sub");
      bus(1'b0, scs_pkg::ADDR_PCC, 32'h0000_0000);
      chk(q === 32'h0000_0037, "pcc read");
      bus(1'b1, scs_pkg::ADDR_PCC, 32'h0000_0000);
      bus(1'b1, scs_pkg::ADDR_MCM, 32'h0000_0001);
      chk(src === 2'b00, "high speed switch one cycle late");
      @(posedge clk_sys);
      #1;
      chk(src === 2'b01, "cpu on high speed");
      $display("test_cpu_switch done");
   endtask : test_cpu_switch
   task automatic test_osc_halt();
      bus(1'b0, scs_pkg::ADDR_MCM, 32'h0000_0000);
      chk(q[1] === 1'b1 && q[3] === 1'b0, "cpu off internal");
      bus(1'b1, scs_pkg::ADDR_RCM, 32'h0000_0001);
      chk(osc === 1'b0 && prun === 1'b0 && pen === 1'b0, "halted");
      bus(1'b1, scs_pkg::ADDR_RCM, 32'h0000_0000);
      chk(osc === 1'b1 && pen === 1'b1, "restarted");
      bus(1'b1, scs_pkg::ADDR_MCM, 32'h0000_0005);
      bus(1'b1, scs_pkg::ADDR_MCM, 32'h0000_0001);
      bus(1'b0, scs_pkg::ADDR_MCM, 32'h0000_0000);
      chk(q[2] === 1'b1, "high speed pick kept");
      bus(1'b1, scs_pkg::ADDR_RCM, 32'h0000_0001);
      chk(prun === 1'b1 && osc === 1'b0, "periph on picked source");
      $display("test_osc_halt done");
   endtask : test_osc_halt
   task automatic test_bypass();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         {t8, pext, cext} <= i[2:0];
         @(posedge clk_sys);
         #1;
         chk(t8b === i[2] && wdt === 1'b1, "timer and watchdog");
         chk(pxb === (i[1] & ~i[0]), "external bypass");
      end
      $display("test_bypass done");
   endtask : test_bypass
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      test_reset_pins();
      test_cpu_switch();
      test_osc_halt();
      test_bypass();
      test_done();
   end
endmodule : tb
`default_nettype wire
